// *** rtl/fcl_defines.vh ***
`ifndef FCL_DEFINES_VH
`define FCL_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FCL_OFS_MODE     8'h00
`define FCL_OFS_CMD      8'h04
`define FCL_OFS_STAT     8'h08
`define FCL_OFS_REMAP    8'h0c
`define FCL_MODE_RST     32'h0000_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCL_MODE_DONE_IE 0
`define FCL_MODE_LOCK_IE 2
`define FCL_MODE_PERR_IE 3
`define FCL_MODE_WS_LSB  8
`define FCL_MODE_TIM_LSB 16
`define FCL_STAT_RDY     0
`define FCL_STAT_DONE    1
`define FCL_STAT_REGION_PROTECT_VIOLATION_FLAG   2
`define FCL_STAT_PERR    3
`define FCL_STAT_LOCK_LSB 16
`define FCL_CMD_PAGE_LSB 8
`define FCL_CMD_KEY_LSB  24

// ----------------------------------------
// Commands, key and memory map
// ----------------------------------------
`define FCL_CMD_PROG     4'h1
`define FCL_CMD_SLOCK    4'h2
`define FCL_CMD_CLOCK    4'h4
`define FCL_CMD_ERASE    4'h8
`define FCL_KEY          8'h5a
`define FCL_BASE_BOOT    12'h000
`define FCL_BASE_FLASH   12'h001
`define FCL_BASE_SRAM    12'h002

// ----------------------------------------
// Timing
// ----------------------------------------
`define FCL_CLK_NS       40
`define FCL_PROG_US      6000
`define FCL_ERASE_US     15000
`define FCL_PROG_CYC  ((`FCL_PROG_US*1000+`FCL_CLK_NS-1)/`FCL_CLK_NS)
`define FCL_ERASE_CYC ((`FCL_ERASE_US*1000+`FCL_CLK_NS-1)/`FCL_CLK_NS)

`endif

// *** rtl/fcl_ctrl.v ***
// Register access over AHB-Lite and the placing of the registers were decided locally.
`include "fcl_defines.vh"

// Overview of operation
// - Before remap, SRAM only at 0x0020_0000
// - After remap, SRAM also aliased at zero
// - Flash always mapped at 0x0010_0000
// - Before remap, flash also at zero
// - Boot ROM never appears in map
// - Flash of 32-bit words in pages
// - Page write buffer, 32-bit write port
// - Flash standby whenever no access runs
// - Arbitrate masters: flash reads, buffer writes
// - Registers: timing, commands, status, interrupt enables
// - Dual 32-bit prefetch buffer for sequential fetches
// - One instance per plane, independent operation
// - Locked erase/program aborts, sets lock error
// - Lock error interrupts only when enabled
// - Set-lock and clear-lock commands change bit
// - Erase pin clears every lock bit
// - Sixteen lock bits per controller
// - Large pages: 64 pages per region
// - Small pages: 32 pages per region
// - Lock bits nonvolatile, changed only by commands and the erase pin
module fcl_ctrl #(
  parameter PAGE_BYTES = 256,             // Bytes per page
  parameter PAGES      = 1024,            // Pages in this plane
  parameter PPR        = 64,              // Pages per lock region
  parameter NLOCK      = 16,              // Lock bits
  parameter [19:0] PROG_CYC  = `FCL_PROG_CYC,   // Program/lock time
  parameter [19:0] ERASE_CYC = `FCL_ERASE_CYC   // Full erase time
) (
  input  wire        sys_clk,     // Master clock
  input  wire        rst,         // Synchronous reset
  input  wire        clk_en,      // Freezes all state when low
  input  wire        hsel,        // AHB select
  input  wire [31:0] haddr,       // AHB address
  input  wire [1:0]  htrans,      // AHB transfer type
  input  wire        hwrite,      // AHB write
  input  wire [2:0]  hsize,       // AHB size
  input  wire [31:0] hwdata,      // AHB write data
  input  wire        hready,      // AHB ready in
  output reg         hreadyout,   // AHB ready out
  output reg  [31:0] hrdata,      // AHB read data
  output reg         hresp,       // AHB response
  input  wire [1:0]  m_req,       // Master requests
  input  wire [63:0] m_addr,      // Master addresses {m1,m0}
  input  wire [1:0]  m_wr,        // Master write flags
  input  wire [63:0] m_wdata,     // Master write data {m1,m0}
  output reg  [1:0]  m_gnt,       // Master served
  output reg         m_ack,       // Access done pulse
  output reg         m_err,       // Unmapped access
  output reg  [31:0] m_rdata,     // Read data
  output reg         sram_req,    // SRAM access pulse
  output reg         sram_we,     // SRAM write
  output reg  [19:0] sram_addr,   // SRAM byte offset
  output reg  [31:0] sram_wdata,  // SRAM write data
  input  wire [31:0] sram_rdata,  // SRAM read data, same cycle as sram_req
  output reg         fl_rd,       // Flash read strobe
  output reg  [19:0] fl_addr,     // Flash byte offset
  input  wire [31:0] fl_rdata,    // Flash read data
  output reg         fl_we,       // Flash latch write
  output reg  [31:0] fl_wdata,    // Flash latch data
  output reg         fl_prog,     // Program running
  output reg         fl_erase,    // Erase running
  output reg         fl_standby,  // Macro in standby
  input  wire        erase_pin,   // Asynchronous erase pin
  input  wire [15:0] nvm_lock_in, // Stored lock cells
  output reg  [15:0] nvm_lock_out,// Lock cells to store
  output reg         remap,       // Remap done
  output reg         irq          // Interrupt
);

  localparam WORDS = PAGE_BYTES / 4;
  localparam MS_IDLE = 2'd0;
  localparam MS_FL   = 2'd1;
  localparam MS_SR   = 2'd2;
  localparam C_IDLE  = 1'b0;
  localparam C_RUN   = 1'b1;
  localparam [9:0] PPR_W = PPR;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Decode: 1 flash, 2 SRAM, 0 nothing
  function [1:0] fcl_decode;
    input [11:0] top;
    input        rm;
    begin
      if (top == `FCL_BASE_FLASH)
        fcl_decode = 2'd1;
      else if (top == `FCL_BASE_SRAM)
        fcl_decode = 2'd2;
      else if (top == `FCL_BASE_BOOT)
        fcl_decode = rm ? 2'd2 : 2'd1;
      else
        fcl_decode = 2'd0;
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [31:0] mode_q;
  reg         wr_pend_q;
  reg  [7:0]  wa_q;
  reg         ers_s1_q, ers_s2_q;
  reg         c_state_q;
  reg  [3:0]  c_cmd_q;
  reg  [9:0]  c_page_q;
  reg  [19:0] c_cnt_q;
  reg  [6:0]  c_wi_q;
  reg         done_q, region_protect_violation_flag_q, perr_q, c_end_q;
  reg  [15:0] lock_q;
  reg  [1:0]  ms_q;
  reg  [1:0]  ws_q;
  reg         m_sel_q, is_pf_q;
  reg  [17:0] f_tag_q;
  reg  [17:0] pf_tag_q [0:1];
  reg  [31:0] pf_dat_q [0:1];
  reg  [1:0]  pf_v_q;
  reg         pf_nxt_q;
  reg  [17:0] pf_want_q;
  reg         pf_want_v_q;
  reg  [31:0] wbuf_q [0:WORDS-1];

  // ----------------------------------------
  // Combinational helpers
  // ----------------------------------------
  wire        a_ok    = hsel & htrans[1] & hready;
  wire        cmd_wr  = clk_en & wr_pend_q & (wa_q == `FCL_OFS_CMD);
  wire        stat_rd = clk_en & a_ok & ~hwrite &
                        (haddr[7:0] == `FCL_OFS_STAT);
  wire [3:0]  n_cmd   = hwdata[3:0];
  wire [9:0]  n_page  = hwdata[`FCL_CMD_PAGE_LSB+9:`FCL_CMD_PAGE_LSB];
  wire [9:0]  n_reg   = n_page / PPR_W;
  wire [3:0]  n_ri    = n_reg[3:0];
  wire        n_rok   = (n_reg < NLOCK) && (n_page < PAGES);
  wire        busy    = (c_state_q == C_RUN);
  wire        c_go    = cmd_wr & ~busy;
  wire        pick    = ~m_req[0];
  wire [31:0] p_addr  = pick ? m_addr[63:32] : m_addr[31:0];
  wire [31:0] p_wdata = pick ? m_wdata[63:32] : m_wdata[31:0];
  wire        p_wr    = pick ? m_wr[1] : m_wr[0];
  wire [1:0]  p_dec   = fcl_decode(p_addr[31:20], remap);
  wire [17:0] p_word  = p_addr[19:2];
  wire [5:0]  p_idx   = p_addr[7:2];
  wire        hit0    = pf_v_q[0] & (pf_tag_q[0] == p_word);
  wire        hit1    = pf_v_q[1] & (pf_tag_q[1] == p_word);
  wire        pf_have = (pf_v_q[0] & (pf_tag_q[0] == pf_want_q)) |
                        (pf_v_q[1] & (pf_tag_q[1] == pf_want_q));

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  // Address phase capture, read data and register writes
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wa_q      <= 8'h00;
      mode_q    <= `FCL_MODE_RST;
      remap     <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend_q <= a_ok & hwrite;
      wa_q      <= haddr[7:0];
      if (wr_pend_q && wa_q == `FCL_OFS_MODE)
        mode_q <= hwdata;
      if (wr_pend_q && wa_q == `FCL_OFS_REMAP && hwdata[0])
        remap <= 1'b1;
      if (a_ok && !hwrite)
      begin
        case (haddr[7:0])
          `FCL_OFS_MODE:  hrdata <= mode_q;
          `FCL_OFS_STAT:  hrdata <= {lock_q, 12'h000, perr_q,
                                     region_protect_violation_flag_q, done_q, ~busy};
          `FCL_OFS_REMAP: hrdata <= {31'h0, remap};
          default:        hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Command sequencer and lock bits
  // ----------------------------------------
  // Erase pin synchroniser
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ers_s1_q <= 1'b0;
      ers_s2_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ers_s1_q <= erase_pin;
      ers_s2_q <= ers_s1_q;
    end
  end

  // Start, lock check, timed run, status flags
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      c_state_q <= C_IDLE;
      c_cmd_q   <= 4'h0;
      c_page_q  <= 10'h000;
      c_cnt_q   <= 20'h00000;
      c_wi_q    <= 7'h00;
      done_q    <= 1'b0;
      region_protect_violation_flag_q   <= 1'b0;
      perr_q    <= 1'b0;
      c_end_q   <= 1'b0;
      lock_q    <= nvm_lock_in;
      fl_prog   <= 1'b0;
      fl_erase  <= 1'b0;
      fl_we     <= 1'b0;
      fl_wdata  <= 32'h0000_0000;
      nvm_lock_out <= 16'h0000;
      irq       <= 1'b0;
    end
    else if (clk_en)
    begin
      c_end_q <= 1'b0;
      fl_we   <= 1'b0;
      if (stat_rd)
      begin
        done_q  <= 1'b0;
        region_protect_violation_flag_q <= 1'b0;
        perr_q  <= 1'b0;
      end
      case (c_state_q)
        C_IDLE:
        begin
          if (cmd_wr)
          begin
            c_cmd_q  <= n_cmd;
            c_page_q <= n_page;
            c_wi_q   <= 7'h00;
            if (hwdata[`FCL_CMD_KEY_LSB+7:`FCL_CMD_KEY_LSB] != `FCL_KEY
                || !n_rok)
              perr_q <= 1'b1;
            else if (n_cmd == `FCL_CMD_PROG && lock_q[n_ri])
              region_protect_violation_flag_q <= 1'b1;
            else if (n_cmd == `FCL_CMD_ERASE && |lock_q)
              region_protect_violation_flag_q <= 1'b1;
            else if (n_cmd == `FCL_CMD_PROG ||
                     n_cmd == `FCL_CMD_SLOCK ||
                     n_cmd == `FCL_CMD_CLOCK)
            begin
              c_state_q <= C_RUN;
              c_cnt_q   <= PROG_CYC;
              fl_prog   <= (n_cmd == `FCL_CMD_PROG);
            end
            else if (n_cmd == `FCL_CMD_ERASE)
            begin
              c_state_q <= C_RUN;
              c_cnt_q   <= ERASE_CYC;
              fl_erase  <= 1'b1;
            end
            else
              perr_q <= 1'b1;
          end
        end
        C_RUN:
        begin
          // Stream the page buffer into the macro latches
          if (fl_prog && c_wi_q < WORDS)
          begin
            fl_we    <= 1'b1;
            fl_wdata <= wbuf_q[c_wi_q[5:0]];
            c_wi_q   <= c_wi_q + 7'h01;
          end
          c_cnt_q <= c_cnt_q - 20'h00001;
          if (c_cnt_q == 20'h00001)
          begin
            c_state_q <= C_IDLE;
            done_q    <= 1'b1;
            c_end_q   <= 1'b1;
            fl_prog   <= 1'b0;
            fl_erase  <= 1'b0;
            if (c_cmd_q == `FCL_CMD_SLOCK)
              lock_q[c_page_q / PPR] <= 1'b1;
            if (c_cmd_q == `FCL_CMD_CLOCK)
              lock_q[c_page_q / PPR] <= 1'b0;
          end
        end
        default:
          c_state_q <= C_IDLE;
      endcase
      if (ers_s2_q)
        lock_q <= 16'h0000;
      nvm_lock_out <= lock_q;
      irq <= (done_q  & mode_q[`FCL_MODE_DONE_IE]) |
             (region_protect_violation_flag_q & mode_q[`FCL_MODE_LOCK_IE]) |
             (perr_q  & mode_q[`FCL_MODE_PERR_IE]);
    end
  end

  // ----------------------------------------
  // Master port, decoder and prefetch
  // ----------------------------------------
  // Arbitration, routing, flash fetch with wait states
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ms_q        <= MS_IDLE;
      ws_q        <= 2'b00;
      m_sel_q     <= 1'b0;
      is_pf_q     <= 1'b0;
      f_tag_q     <= 18'h00000;
      pf_v_q      <= 2'b00;
      pf_nxt_q    <= 1'b0;
      pf_want_q   <= 18'h00000;
      pf_want_v_q <= 1'b0;
      m_gnt       <= 2'b00;
      m_ack       <= 1'b0;
      m_err       <= 1'b0;
      m_rdata     <= 32'h0000_0000;
      sram_req    <= 1'b0;
      sram_we     <= 1'b0;
      sram_addr   <= 20'h00000;
      sram_wdata  <= 32'h0000_0000;
      fl_rd       <= 1'b0;
      fl_addr     <= 20'h00000;
      fl_standby  <= 1'b1;
    end
    else if (clk_en)
    begin
      m_ack    <= 1'b0;
      m_err    <= 1'b0;
      m_gnt    <= 2'b00;
      sram_req <= 1'b0;
      sram_we  <= 1'b0;
      if (c_end_q)
        pf_v_q <= 2'b00;
      // Standby unless a command or fetch runs next cycle
      fl_standby <= ~(busy | c_go);
      case (ms_q)
        MS_IDLE:
        begin
          fl_rd <= 1'b0;
          if (|m_req && !m_ack)
          begin
            m_sel_q <= pick;
            if (p_dec == 2'd2)
            begin
              sram_req   <= 1'b1;
              sram_we    <= p_wr;
              sram_addr  <= p_addr[19:0];
              sram_wdata <= p_wdata;
              if (p_wr)
              begin
                m_ack <= 1'b1;
                m_gnt <= pick ? 2'b10 : 2'b01;
              end
              else
                ms_q <= MS_SR;
            end
            else if (p_dec == 2'd0 || (p_wr && p_idx >= WORDS))
            begin
              m_ack <= 1'b1;
              m_err <= 1'b1;
              m_gnt <= pick ? 2'b10 : 2'b01;
            end
            else if (!busy && p_wr)
            begin
              wbuf_q[p_idx] <= p_wdata;
              m_ack <= 1'b1;
              m_gnt <= pick ? 2'b10 : 2'b01;
            end
            else if (!busy && (hit0 || hit1))
            begin
              m_rdata     <= hit0 ? pf_dat_q[0] : pf_dat_q[1];
              m_ack       <= 1'b1;
              m_gnt       <= pick ? 2'b10 : 2'b01;
              pf_want_q   <= p_word + 18'h00001;
              pf_want_v_q <= 1'b1;
            end
            else if (!busy)
            begin
              ms_q    <= MS_FL;
              is_pf_q <= 1'b0;
              f_tag_q <= p_word;
              fl_rd   <= 1'b1;
              fl_addr <= {p_word, 2'b00};
              fl_standby <= 1'b0;
              ws_q    <= mode_q[`FCL_MODE_WS_LSB+1:`FCL_MODE_WS_LSB];
            end
          end
          else if (!busy && pf_want_v_q && !pf_have && !c_end_q)
          begin
            ms_q    <= MS_FL;
            is_pf_q <= 1'b1;
            f_tag_q <= pf_want_q;
            fl_rd   <= 1'b1;
            fl_addr <= {pf_want_q, 2'b00};
            fl_standby <= 1'b0;
            ws_q    <= mode_q[`FCL_MODE_WS_LSB+1:`FCL_MODE_WS_LSB];
          end
        end
        MS_FL:
        begin
          if (ws_q != 2'b00)
          begin
            ws_q       <= ws_q - 2'b01;
            fl_standby <= 1'b0;
          end
          else
          begin
            ms_q     <= MS_IDLE;
            fl_rd    <= 1'b0;
            pf_tag_q[pf_nxt_q] <= f_tag_q;
            pf_dat_q[pf_nxt_q] <= fl_rdata;
            pf_v_q[pf_nxt_q]   <= 1'b1;
            pf_nxt_q <= ~pf_nxt_q;
            pf_want_q   <= f_tag_q + 18'h00001;
            pf_want_v_q <= 1'b1;
            if (!is_pf_q)
            begin
              m_rdata <= fl_rdata;
              m_ack   <= 1'b1;
              m_gnt   <= m_sel_q ? 2'b10 : 2'b01;
            end
          end
        end
        MS_SR:
        begin
          ms_q    <= MS_IDLE;
          m_rdata <= sram_rdata;
          m_ack   <= 1'b1;
          m_gnt   <= m_sel_q ? 2'b10 : 2'b01;
        end
        default:
          ms_q <= MS_IDLE;
      endcase
    end
  end

endmodule // fcl_ctrl

// *** verification/fcl_ctrl_chk.sv ***
module fcl_ctrl_chk (
  input wire        sys_clk,      // Master clock
  input wire        rst,          // Synchronous reset
  input wire        hreadyout,    // Bus ready
  input wire        hresp,        // Bus response
  input wire [1:0]  m_gnt,        // Served master
  input wire        m_ack,        // Access done
  input wire        m_err,        // Access error
  input wire        fl_prog,      // Program running
  input wire        fl_erase,     // Erase running
  input wire        fl_standby,   // Macro standby
  input wire        erase_pin,    // Erase pin
  input wire [15:0] nvm_lock_out, // Lock bits
  input wire        remap,        // Remap done
  input wire        irq           // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_ack_one_gnt: assert property (m_ack |-> $onehot(m_gnt))
    else $error("ack without single grant");
  a_gnt_needs_ack: assert property (!m_ack |-> m_gnt == 2'b00)
    else $error("grant without ack");
  a_err_with_ack: assert property (m_err |-> m_ack)
    else $error("error without ack");
  a_ack_single: assert property (m_ack |=> !m_ack)
    else $error("ack longer than one cycle");
  a_busy_awake: assert property ((fl_prog || fl_erase) |-> !fl_standby)
    else $error("standby while command runs");
  a_one_command: assert property (!(fl_prog && fl_erase))
    else $error("program and erase together");
  a_remap_sticky: assert property (remap |=> remap)
    else $error("remap dropped");
  a_erase_unlocks: assert property (erase_pin [*5] |=> nvm_lock_out == 16'h0000)
    else $error("locks kept under erase pin");
  c_error_ack: cover property (m_ack && m_err);
  c_program: cover property ($fell(fl_prog));
  c_erase: cover property ($fell(fl_erase));
  c_irq: cover property ($rose(irq));
endmodule // fcl_ctrl_chk

bind fcl_ctrl fcl_ctrl_chk fcl_ctrl_chk_i (.*);

// *** verification/fcl_mst_model.sv ***
module fcl_mst_model (
  input  wire         sys_clk, // Master clock
  output logic [1:0]  m_req,   // Requests
  output logic [63:0] m_addr,  // Addresses {m1,m0}
  output logic [1:0]  m_wr,    // Write flags
  output logic [63:0] m_wdata, // Write data {m1,m0}
  input  wire  [1:0]  m_gnt,   // Served master
  input  wire         m_ack,   // Access done
  input  wire         m_err,   // Access error
  input  wire  [31:0] m_rdata  // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus master behaviour
  // ----------------------------------------
  initial
  begin
    m_req = 2'b00;
    m_addr = 64'h0;
    m_wr = 2'b00;
    m_wdata = 64'h0;
  end
  // One access, held until its own acknowledge is sampled
  task automatic access(input int i, input [31:0] a, input w,
    input [31:0] wd, output [31:0] rd, output e, output int lat);
    int n;
    begin
      n = 0;
      @(posedge sys_clk);
      m_req[i] <= 1'b1;
      m_addr[i*32 +: 32] <= a;
      m_wr[i] <= w;
      m_wdata[i*32 +: 32] <= wd;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (!(m_ack === 1'b1 && m_gnt[i] === 1'b1) && n < 64);
      rd = m_rdata;
      e = m_err;
      lat = n;
      // Released lines stop showing the old value
      m_req[i] <= 1'b0;
      m_addr[i*32 +: 32] <= ~a;
      m_wdata[i*32 +: 32] <= ~wd;
      repeat (4) @(posedge sys_clk);
    end
  endtask
endmodule // fcl_mst_model

// *** verification/test_flash_ctrl_lock_remap.sv ***
module test_flash_ctrl_lock_remap;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {bit rm; int mi; logic [31:0] a; bit w;
    logic [31:0] wd; logic e; logic [31:0] rd;} fcl_row_t;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        erase_pin = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] fw0 = 32'h0;
  logic [15:0] nvm_lock_in = 16'h0002;
  logic [31:0] sram_mem [0:15];
  wire         hready, hreadyout, hresp, m_ack, m_err, sram_req, sram_we;
  wire         fl_rd, fl_we, fl_prog, fl_erase, fl_standby, remap, irq;
  wire  [31:0] hrdata, m_rdata, sram_wdata, fl_wdata, fl_rdata, sram_rdata;
  wire  [19:0] sram_addr, fl_addr;
  wire  [1:0]  m_gnt, m_req, m_wr;
  wire  [63:0] m_addr, m_wdata;
  wire  [15:0] nvm_lock_out;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          we_cnt = 0;
  int          prog_cnt = 0;
  int          era_cnt = 0;
  fcl_row_t    rows [10] = '{
    '{0, 0, 32'h0010_0040, 0, 0, 0, 32'hf1a0_0040},
    '{0, 1, 32'h0000_0040, 0, 0, 0, 32'hf1a0_0040},
    '{0, 0, 32'h0020_0010, 1, 32'hcafe_0001, 0, 0},
    '{0, 1, 32'h0020_0010, 0, 0, 0, 32'hcafe_0001},
    '{0, 0, 32'h0000_0010, 0, 0, 0, 32'hf1a0_0010},
    '{0, 0, 32'h0030_0000, 0, 0, 1, 0},
    '{0, 0, 32'h0010_0000, 1, 32'h1234_5678, 0, 0},
    '{1, 0, 32'h0000_0010, 0, 0, 0, 32'hcafe_0001},
    '{0, 1, 32'h0020_0010, 0, 0, 0, 32'hcafe_0001},
    '{0, 0, 32'h0010_0040, 0, 0, 0, 32'hf1a0_0040}};
  assign hready = hreadyout;
  assign fl_rdata = fl_rd ? {12'hf1a, fl_addr} : ~{12'hf1a, fl_addr};
  assign sram_rdata = sram_req ? sram_mem[sram_addr[5:2]]
                               : ~sram_mem[sram_addr[5:2]];
  fcl_ctrl #(.PROG_CYC(20'd80), .ERASE_CYC(20'd90)) fcl_ctrl_i (.*);
  fcl_mst_model fcl_mst_model_i (.*);
  // Clock
  always #20 sys_clk = ~sys_clk;
  // SRAM answers within the request cycle; counters of flash strobes
  always @(posedge sys_clk)
  begin
    if (sram_req && sram_we)
      sram_mem[sram_addr[5:2]] <= sram_wdata;
    if (fl_we === 1'b1 && we_cnt == 0)
      fw0 <= fl_wdata;
    we_cnt <= we_cnt + (fl_we === 1'b1);
    prog_cnt <= prog_cnt + (fl_prog === 1'b1);
    era_cnt <= era_cnt + (fl_erase === 1'b1);
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input [31:0] seen, input [31:0] exp, input string msg);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        error_cnt++;
        $display("FAIL t=%0t %s seen %h expected %h", $time, msg, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // An unanswered master access ends the run
  task acc_limit(input int lat);
    begin
      if (lat >= 64)
      begin
        error_cnt++;
        tally_and_finish();
      end
    end
  endtask
  // Wait for hready sampled high, bounded
  task ahb_phase;
    int n;
    begin
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1)
      begin
        error_cnt++;
        tally_and_finish();
      end
    end
  endtask
  task ahb_xfer(input [7:0] a, input w, input [31:0] wd, output [31:0] rd);
    begin
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      ahb_phase();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w ? wd : 32'h0;
      ahb_phase();
      rd = hrdata;
    end
  endtask
  // Poll status until ready, bounded
  task poll(output [31:0] st);
    int n;
    begin
      n = 0;
      do
      begin
        ahb_xfer(8'h08, 1'b0, 32'h0, st);
        n++;
      end
      while (st[0] !== 1'b1 && n < 100);
      if (st[0] !== 1'b1)
      begin
        error_cnt++;
        tally_and_finish();
      end
    end
  endtask
  task run_cmd(input [31:0] c, output [31:0] st, output logic iq);
    logic [31:0] d;
    begin
      ahb_xfer(8'h04, 1'b1, c, d);
      repeat (4) @(posedge sys_clk);
      iq = irq;
      poll(st);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [31:0] st;
    logic        e;
    logic        iq;
    int          l0;
    int          l1;
    int          w0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check({29'h0, remap, irq, fl_standby}, 32'h1, "reset outputs");
    ahb_xfer(8'h00, 1'b0, 32'h0, d);
    check(d, 32'h0, "mode reset");
    ahb_xfer(8'h08, 1'b0, 32'h0, d);
    check(d, 32'h0002_0001, "status reset");
    ahb_xfer(8'h10, 1'b0, 32'h0, d);
    check(d, 32'h0, "unmapped offset");
    $display("test reset done");
    foreach (rows[k])
    begin
      if (rows[k].rm)
        ahb_xfer(8'h0c, 1'b1, 32'h1, d);
      fcl_mst_model_i.access(rows[k].mi, rows[k].a, rows[k].w,
        rows[k].wd, d, e, l0);
      acc_limit(l0);
      check({31'h0, e}, {31'h0, rows[k].e}, "access error");
      if (!rows[k].w && !rows[k].e)
        check(d, rows[k].rd, "read data");
    end
    ahb_xfer(8'h0c, 1'b0, 32'h0, d);
    check(d, 32'h1, "remap readback");
    $display("test address map done");
    fcl_mst_model_i.access(0, 32'h0010_0200, 1'b0, 32'h0, d, e, l0);
    acc_limit(l0);
    fcl_mst_model_i.access(0, 32'h0010_0204, 1'b0, 32'h0, d, e, l1);
    acc_limit(l1);
    check(d, 32'hf1a0_0204, "prefetched word");
    check({31'h0, l1 < l0}, 32'h1, "prefetch hit faster");
    fork
      fcl_mst_model_i.access(0, 32'h0020_0000, 1'b1, 32'h1, d, e, l0);
      fcl_mst_model_i.access(1, 32'h0020_0004, 1'b1, 32'h2, d, e, l1);
    join
    acc_limit(l0);
    acc_limit(l1);
    check({31'h0, l1 > l0}, 32'h1, "master priority");
    $display("test prefetch and arbitration done");
    for (int ie = 1; ie >= 0; ie--)
    begin
      ahb_xfer(8'h00, 1'b1, ie << 2, d);
      run_cmd(32'h5a00_4001, st, iq);
      check(st, 32'h0002_0005, "locked program status");
      check({31'h0, iq}, ie, "lock error interrupt");
    end
    run_cmd(32'h5a00_0008, st, iq);
    check(st, 32'h0002_0005, "locked erase status");
    check(prog_cnt + era_cnt, 32'h0, "aborted commands idle");
    $display("test lock errors done");
    w0 = we_cnt;
    ahb_xfer(8'h04, 1'b1, 32'h5a00_0001, d);
    ahb_xfer(8'h04, 1'b1, 32'h5a00_0002, d);
    ahb_xfer(8'h08, 1'b0, 32'h0, st);
    check(st, 32'h0002_0000, "busy status");
    check({30'h0, fl_prog, fl_standby}, 32'h2, "program awake");
    poll(st);
    check(st, 32'h0002_0003, "program done, lock refused");
    check(we_cnt - w0, 32'd64, "buffer words streamed");
    check(fw0, 32'h1234_5678, "first buffer word");
    run_cmd(32'h5a00_0002, st, iq);
    check(st, 32'h0003_0003, "set lock");
    run_cmd(32'h5a00_4004, st, iq);
    check(st, 32'h0001_0003, "clear lock");
    check({16'h0, nvm_lock_out}, 32'h1, "stored locks");
    run_cmd(32'h0000_8001, st, iq);
    check(st, 32'h0001_0009, "bad key");
    $display("test commands done");
    @(posedge sys_clk);
    erase_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    erase_pin <= 1'b0;
    ahb_xfer(8'h08, 1'b0, 32'h0, st);
    check(st, 32'h0000_0001, "erase pin unlocks");
    run_cmd(32'h5a00_0008, st, iq);
    check(st, 32'h0000_0003, "full erase done");
    check({31'h0, era_cnt > 0}, 32'h1, "erase ran");
    $display("test erase done");
    tally_and_finish();
  end
endmodule // test_flash_ctrl_lock_remap
